// file: pkg/adcseq_pkg.sv
// Purpose: Shared constants and carrier types for the converter sequencer
// Assumes: 8-bit control writes arrive as a strobe with a data byte
// Notes: Field layout of the control byte is fixed here for all users
package adcseq_pkg;
    // Control byte fields
    localparam int CTL_BUSY_POS = 0;
    localparam int CTL_CHAN_LSB = 1;
    localparam int CTL_CHAN_W = 3;
    localparam int CTL_MODE_LSB = 4;
    localparam int CTL_MODE_W = 2;
    localparam int CTL_PRESC_POS = 6;
    localparam logic [7:0] CTL_RESET = 8'h00;
    // Gain register fields
    localparam int GAIN_TS_POS = 4;
    localparam int GAIN_TRIM_POS = 3;
    localparam logic [7:0] GAIN_RESET = 8'h00;
    localparam logic [7:0] TRIM_RESET = 8'h40;
    // Sequence timing in converter clocks
    localparam int SAMPLE_CYC = 3;
    localparam int AZERO_CYC = 1;
    localparam int BIT_CYC = 10;
    localparam int LOAD_CYC = 1;
    localparam int CONV_CYC = SAMPLE_CYC + AZERO_CYC + BIT_CYC + LOAD_CYC;
    localparam int PRESC_SLOW = 16;
    localparam int PRESC_FAST = 8;
    localparam logic [2:0] TEMP_CHAN = 3'h7;
    // Phases of a conversion
    typedef enum logic [2:0] {
        ADCSEQ_IDLE = 3'b000,
        ADCSEQ_SAMPLE = 3'b001,
        ADCSEQ_AZERO = 3'b011,
        ADCSEQ_DECIDE = 3'b010,
        ADCSEQ_COMPLETE = 3'b110
    } adcseq_phase_t;
    // Software write to a byte register
    typedef struct packed {
        logic wr;
        logic [7:0] data;
    } adcseq_wr_t;
endpackage : adcseq_pkg

// file: hw/adcseq_core.sv
// Purpose: Conversion control and sequencing of a 10-bit SAR converter
// Assumes: Comparator decision arrives synchronous to sys_clk
// Notes: Converter clock is an enable pulse every prescale main clocks
`timescale 1ns/10ps
module adcseq_core #(
    parameter int PRESC_A = adcseq_pkg::PRESC_FAST,
    parameter int PRESC_B = adcseq_pkg::PRESC_SLOW
) (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic clk_en,
    input wire adcseq_pkg::adcseq_wr_t ctl_wr,
    input wire adcseq_pkg::adcseq_wr_t gain_wr,
    input wire adcseq_pkg::adcseq_wr_t ntrim_wr,
    input wire adcseq_pkg::adcseq_wr_t ptrim_wr,
    input wire logic low_power,
    input wire logic breakpoint,
    input wire logic cmp_out,
    output logic [7:0] conv_control_reg,
    output logic [7:0] amp_gain_reg,
    output logic [7:0] n_trim_reg,
    output logic [7:0] p_trim_reg,
    output logic [1:0] result_high_reg,
    output logic [7:0] result_low_reg,
    output logic conv_power_reg,
    output logic sample_reg,
    output logic azero_reg,
    output logic conv_clk_en_reg,
    output logic temp_sel_reg,
    output logic temp_sensor_enable
);
    import adcseq_pkg::*;

    // The divider counter is eight bits wide, so larger prescalers cannot be served
    if (PRESC_A < 2 || PRESC_B < 2 || PRESC_A > 255 || PRESC_B > 255) begin : gen_presc_check
        $error("Prescaler values must lie in 2..255");
    end

    adcseq_phase_t phase_reg, phase_next;
    logic [7:0] ctl_next, gain_next, ntrim_next, ptrim_next;
    logic [7:0] div_reg, div_next;
    logic [3:0] cnt_reg, cnt_next;
    logic [9:0] sar_reg, sar_next;
    logic [9:0] res_next;
    logic restart_reg, restart_next;
    logic tick;
    logic busy;
    logic [7:0] div_top;

    assign busy = conv_control_reg[CTL_BUSY_POS];
    assign div_top = conv_control_reg[CTL_PRESC_POS] ? 8'(PRESC_B - 1) : 8'(PRESC_A - 1);
    // Converter clock tick only exists while busy and awake
    assign tick = busy && !low_power && (div_reg == div_top);

    // Register writes and completion side effects
    always_comb begin
        ctl_next = conv_control_reg;
        gain_next = amp_gain_reg;
        ntrim_next = n_trim_reg;
        ptrim_next = p_trim_reg;
        res_next = {result_high_reg, result_low_reg};
        if (ctl_wr.wr) begin
            if (busy) begin
                // Only busy bit takes the write; clearing it aborts
                ctl_next[CTL_BUSY_POS] = ctl_wr.data[CTL_BUSY_POS];
            end else begin
                ctl_next = ctl_wr.data;
            end
        end
        if (tick && phase_reg == ADCSEQ_COMPLETE && !(ctl_wr.wr && !ctl_wr.data[CTL_BUSY_POS])) begin
            ctl_next[CTL_BUSY_POS] = 1'b0;
            res_next = sar_reg;
        end
        if (gain_wr.wr) begin
            gain_next = gain_wr.data;
        end
        if (ntrim_wr.wr) begin
            ntrim_next = ntrim_wr.data;
        end
        if (ptrim_wr.wr) begin
            ptrim_next = ptrim_wr.data;
        end
    end

    // Sequence: phase counter advanced by converter clock ticks
    always_comb begin
        phase_next = phase_reg;
        cnt_next = cnt_reg;
        sar_next = sar_reg;
        div_next = 8'h00;
        restart_next = restart_reg;
        if (!busy || (ctl_wr.wr && busy && !ctl_wr.data[CTL_BUSY_POS])) begin
            phase_next = ADCSEQ_IDLE;
            cnt_next = 4'h0;
            restart_next = 1'b0;
        end else if (low_power) begin
            // Breakpoint is not a low-power state, so it never lands here
            phase_next = ADCSEQ_IDLE;
            cnt_next = 4'h0;
            restart_next = 1'b1;
        end else begin
            div_next = tick ? 8'h00 : div_reg + 8'h01;
            if (tick) begin
                unique case (phase_reg)
                    ADCSEQ_IDLE: begin
                        phase_next = ADCSEQ_SAMPLE;
                        cnt_next = 4'h0;
                        sar_next = 10'h000;
                    end
                    ADCSEQ_SAMPLE: begin
                        cnt_next = cnt_reg + 4'h1;
                        if (cnt_reg == 4'(SAMPLE_CYC - 1)) begin
                            phase_next = ADCSEQ_AZERO;
                            cnt_next = 4'h0;
                        end
                    end
                    ADCSEQ_AZERO: begin
                        phase_next = ADCSEQ_DECIDE;
                    end
                    ADCSEQ_DECIDE: begin
                        sar_next = {sar_reg[8:0], cmp_out};
                        cnt_next = cnt_reg + 4'h1;
                        if (cnt_reg == 4'(BIT_CYC - 1)) begin
                            phase_next = ADCSEQ_COMPLETE;
                            cnt_next = 4'h0;
                        end
                    end
                    ADCSEQ_COMPLETE: begin
                        phase_next = ADCSEQ_IDLE;
                        restart_next = 1'b0;
                    end
                endcase
            end
        end
    end

    // State registers; clk_en freezes everything
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            conv_control_reg <= CTL_RESET;
            amp_gain_reg <= GAIN_RESET;
            n_trim_reg <= TRIM_RESET;
            p_trim_reg <= TRIM_RESET;
            result_high_reg <= 2'h0;
            result_low_reg <= 8'h00;
            phase_reg <= ADCSEQ_IDLE;
            cnt_reg <= 4'h0;
            sar_reg <= 10'h000;
            div_reg <= 8'h00;
            restart_reg <= 1'b0;
            conv_power_reg <= 1'b0;
            sample_reg <= 1'b0;
            azero_reg <= 1'b0;
            conv_clk_en_reg <= 1'b0;
            temp_sel_reg <= 1'b0;
            temp_sensor_enable <= 1'b0;
        end else if (clk_en) begin
            conv_control_reg <= ctl_next;
            amp_gain_reg <= gain_next;
            n_trim_reg <= ntrim_next;
            p_trim_reg <= ptrim_next;
            {result_high_reg, result_low_reg} <= res_next;
            phase_reg <= phase_next;
            cnt_reg <= cnt_next;
            sar_reg <= sar_next;
            div_reg <= div_next;
            restart_reg <= restart_next;
            // Power follows busy at once so the write cycle itself powers up
            conv_power_reg <= ctl_next[CTL_BUSY_POS] && !low_power;
            sample_reg <= (phase_next == ADCSEQ_SAMPLE);
            azero_reg <= (phase_next == ADCSEQ_AZERO);
            conv_clk_en_reg <= ctl_next[CTL_BUSY_POS] && !low_power;
            temp_sel_reg <= (ctl_next[CTL_CHAN_LSB +: CTL_CHAN_W] == TEMP_CHAN);
            temp_sensor_enable <= gain_next[GAIN_TS_POS];
        end
    end

    // Checks
    int unsigned conv_ticks;
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            conv_ticks <= 0;
        end else if (clk_en) begin
            conv_ticks <= (phase_next == ADCSEQ_IDLE) ? 0 : (tick ? conv_ticks + 1 : conv_ticks);
        end
    end

    busy_ignore_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        clk_en && busy && ctl_wr.wr |=> conv_control_reg[7:1] == $past(conv_control_reg[7:1]))
        else $error("Control bits changed while busy");
    start_power_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        clk_en && !busy && ctl_wr.wr && ctl_wr.data[0] && !low_power |=> conv_power_reg && busy)
        else $error("Start write did not power up");
    idle_power_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        !busy |-> !conv_clk_en_reg && !conv_power_reg && div_reg == 8'h00)
        else $error("Converter clock ran while idle");
    sample_len_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        $fell(sample_reg) && azero_reg |-> conv_ticks == SAMPLE_CYC + 1)
        else $error("Sample window wrong");
    conv_len_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        clk_en && tick && phase_reg == ADCSEQ_COMPLETE |-> conv_ticks == CONV_CYC)
        else $error("Conversion length not fifteen");
    done_clear_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        clk_en && tick && phase_reg == ADCSEQ_COMPLETE && !ctl_wr.wr |=> !busy && !conv_power_reg)
        else $error("Completion did not clear busy");
    result_load_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        clk_en && tick && phase_reg == ADCSEQ_COMPLETE && !ctl_wr.wr
        |=> {result_high_reg, result_low_reg} == $past(sar_reg))
        else $error("Result not loaded whole");
    abort_keep_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        clk_en && busy && ctl_wr.wr && !ctl_wr.data[0]
        |=> $stable({result_high_reg, result_low_reg}) && phase_reg == ADCSEQ_IDLE)
        else $error("Abort disturbed result");
    halt_down_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        clk_en && low_power |=> !conv_power_reg && phase_reg == ADCSEQ_IDLE)
        else $error("Converter powered in low power mode");
    temp_route_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        clk_en && conv_control_reg[3:1] == TEMP_CHAN && !ctl_wr.wr |=> temp_sel_reg)
        else $error("Sensor channel not routed");
    brk_cont_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        clk_en && breakpoint && busy && !ctl_wr.wr && !(tick && phase_reg == ADCSEQ_COMPLETE)
        |=> busy)
        else $error("Breakpoint disturbed conversion");

    conv_done_c: cover property (@(posedge sys_clk) disable iff (!nrst)
        tick && phase_reg == ADCSEQ_COMPLETE);
    abort_c: cover property (@(posedge sys_clk) disable iff (!nrst)
        busy && ctl_wr.wr && !ctl_wr.data[0]);
    wake_restart_c: cover property (@(posedge sys_clk) disable iff (!nrst)
        restart_reg && $fell(low_power));
endmodule : adcseq_core

// file: verification/tb_top.sv
// Purpose: Self-checking bench for the converter sequencer core
// Assumes: Prescalers of 32 and 16 main clocks keep the converter clock in range
// Notes: Comparator held steady per conversion, so a result is all ones or all zeros
`timescale 1ns/10ps
module tb_top;
    import adcseq_pkg::*;
    localparam int PA = 32;
    localparam int PB = 16;
    logic sys_clk = 1'b0;
    logic nrst = 1'b0;
    adcseq_wr_t ctl_wr = '0;
    adcseq_wr_t gain_wr = '0;
    adcseq_wr_t ntrim_wr = '0;
    adcseq_wr_t ptrim_wr = '0;
    logic low_power = 1'b0;
    logic breakpoint = 1'b0;
    logic cmp_out = 1'b0;
    logic clk_en = 1'b1;
    logic [7:0] trim = 8'h00;
    // Amplifier settling of 1.05 ms in 40 ns main clocks
    localparam int SETTLE_CYC = 26250;
    localparam logic [7:0] GAIN_TRIM = 8'h01 << GAIN_TRIM_POS;
    logic [7:0] conv_control_reg, amp_gain_reg, n_trim_reg, p_trim_reg, result_low_reg;
    logic [1:0] result_high_reg;
    logic conv_power_reg, sample_reg, azero_reg, conv_clk_en_reg, temp_sel_reg, temp_sensor_enable;
    int n_fail = 0;
    int tests_run = 0;
    logic [7:0] exp_ctl = 8'h00;
    logic [9:0] exp_res = 10'h000;
    logic [31:0] seed = 32'h52D5671E;
    // Free-running main clock, 40 ns period
    always #20 sys_clk = ~sys_clk;
    adcseq_core #(.PRESC_A(PA), .PRESC_B(PB)) dut (.sys_clk(sys_clk), .nrst(nrst),
        .clk_en(clk_en), .ctl_wr(ctl_wr), .gain_wr(gain_wr), .ntrim_wr(ntrim_wr),
        .ptrim_wr(ptrim_wr), .low_power(low_power), .breakpoint(breakpoint),
        .cmp_out(cmp_out), .conv_control_reg(conv_control_reg), .amp_gain_reg(amp_gain_reg),
        .n_trim_reg(n_trim_reg), .p_trim_reg(p_trim_reg), .result_high_reg(result_high_reg),
        .result_low_reg(result_low_reg), .conv_power_reg(conv_power_reg),
        .sample_reg(sample_reg), .azero_reg(azero_reg), .conv_clk_en_reg(conv_clk_en_reg),
        .temp_sel_reg(temp_sel_reg), .temp_sensor_enable(temp_sensor_enable));
    // Galois-free shift register, enough spread for channel and comparator picks
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    // Inputs move a fixed 1 ns after the edge so no race with the design's sampling
    task automatic tick(input int n = 1);
        repeat (n) begin
            @(posedge sys_clk);
            #1;
        end
    endtask : tick
    task automatic chk(input string nm, input logic [9:0] e, input logic [9:0] g);
        tests_run++;
        if (g !== e) begin
            $display("unexpected %0s: expected %0h seen %0h", nm, e, g);
            n_fail++;
        end
    endtask : chk
    task automatic end_sim();
        $display("checks %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : end_sim
    // Model: while busy only the busy bit takes a write
    task automatic wr_ctl(input logic [7:0] d);
        ctl_wr = '{1'b1, d};
        exp_ctl = exp_ctl[0] ? {exp_ctl[7:1], d[0]} : d;
        tick();
        ctl_wr.wr = 1'b0;
        tick();
    endtask : wr_ctl
    // Gain and P trim writes travel together as one pulse
    task automatic wr_amp(input logic [7:0] g, input logic [7:0] t);
        gain_wr = '{1'b1, g};
        ptrim_wr = '{1'b1, t};
        tick();
        gain_wr.wr = 1'b0;
        ptrim_wr.wr = 1'b0;
        tick();
    endtask : wr_amp
    task automatic start(input logic [7:0] d, input logic c);
        cmp_out = c;
        wr_ctl(d);
        chk("control", exp_ctl, conv_control_reg);
        chk("power up", 1, conv_power_reg);
    endtask : start
    // Waits for completion; limits keep a hung sequence from stalling the run
    task automatic finish(input int p);
        int n = 0;
        int ns = 0;
        int na = 0;
        while (n < 1000 && conv_control_reg[0] !== 1'b0) begin
            tick();
            n++;
            ns += (sample_reg === 1'b1);
            na += (azero_reg === 1'b1);
        end
        exp_ctl[0] = 1'b0;
        exp_res = cmp_out ? 10'h3FF : 10'h000;
        chk("duration", 1, n >= 15 * p - 3 && n <= 16 * p + 3);
        chk("sample cycles", 3 * p, ns);
        chk("azero cycles", p, na);
        chk("result", exp_res, {result_high_reg, result_low_reg});
        chk("power down", 0, {conv_power_reg, conv_clk_en_reg});
        chk("control done", exp_ctl, conv_control_reg);
    endtask : finish
    initial begin
        tick(6);
        nrst = 1'b1;
        chk("reset n trim", {2'b00, TRIM_RESET}, n_trim_reg);
        chk("reset p trim", {2'b00, TRIM_RESET}, p_trim_reg);
        chk("reset gain", 0, {amp_gain_reg, temp_sensor_enable, conv_power_reg});
        // Every prescaler and comparator level, random channel and mode
        for (int i = 0; i < 4; i++) begin
            seed = lfsr(seed);
            start({1'b0, i[1], seed[5:1], 1'b1}, i[0]);
            finish(i[1] ? PB : PA);
        end
        $display("test conversions done");
        // Write with all bits set mid-conversion only keeps busy
        start(8'h01, 1'b1);
        wr_ctl(8'hFF);
        finish(PA);
        $display("test locked control done");
        // Abort keeps old result, one write reloads all fields and restarts
        start(8'h41, 1'b0);
        tick(40);
        wr_ctl(8'h00);
        chk("abort result", exp_res, {result_high_reg, result_low_reg});
        chk("abort power", 0, conv_power_reg);
        start(8'h0F, 1'b0);
        chk("temp select", 1, temp_sel_reg);
        finish(PA);
        $display("test abort done");
        // Breakpoint held throughout must not disturb the sequence
        breakpoint = 1'b1;
        start(8'h31, 1'b1);
        finish(PA);
        breakpoint = 1'b0;
        // Low power mid-conversion powers down and restarts from the first cycle
        start(8'h01, 1'b0);
        tick(50);
        low_power = 1'b1;
        tick(20);
        chk("sleep power", 0, conv_power_reg);
        chk("sleep busy", 1, conv_control_reg[0]);
        low_power = 1'b0;
        finish(PA);
        $display("test breakpoint and sleep done");
        // Software trims the P pair: one magnitude bit per pass, overshoots cleared
        seed = lfsr(seed);
        trim = 8'hC0;
        wr_amp(GAIN_TRIM, trim);
        tick(SETTLE_CYC);
        start(8'h01, seed[7]);
        finish(PA);
        // A steady comparator gives all ones or all zeros, never a mixed top
        if (exp_res[9:7] == 3'b000) begin
            trim[6] = 1'b0;
        end
        for (int b = 5; b >= 0; b--) begin
            trim[b] = 1'b1;
            wr_amp(GAIN_TRIM, trim);
            seed = lfsr(seed);
            start(8'h01, seed[7]);
            finish(PA);
            if ((exp_res[9:7] == 3'b111) != trim[6]) begin
                trim[b] = 1'b0;
            end
        end
        trim[7] = 1'b0;
        wr_amp(8'h00, trim);
        chk("trim kept", {2'b00, trim}, p_trim_reg);
        chk("trim mode", 0, amp_gain_reg);
        $display("test trim done");
        // Clock enable low freezes every register against a pending write
        clk_en = 1'b0;
        gain_wr = '{1'b1, 8'h10};
        ntrim_wr = '{1'b1, 8'hC0};
        ptrim_wr = '{1'b1, 8'hC0};
        tick(2);
        chk("freeze gain", 0, {amp_gain_reg, temp_sensor_enable});
        chk("freeze trim", {2'b00, trim}, p_trim_reg);
        // Sensor enable and trims follow writes, reset clears the enable
        clk_en = 1'b1;
        tick();
        gain_wr.wr = 1'b0;
        ntrim_wr.wr = 1'b0;
        ptrim_wr.wr = 1'b0;
        tick();
        chk("sensor on", 10'h110, {1'b0, temp_sensor_enable, amp_gain_reg});
        chk("n trim", 10'h0C0, n_trim_reg);
        chk("p trim", 10'h0C0, p_trim_reg);
        nrst = 1'b0;
        tick();
        nrst = 1'b1;
        chk("sensor reset", 0, {temp_sensor_enable, amp_gain_reg});
        chk("trim reset", {2'b00, TRIM_RESET}, p_trim_reg);
        $display("test sensor done");
        end_sim();
    end
    // Watchdog well above the thirty-four thousand or so cycles the tests need
    initial begin
        #(40 * 80000);
        n_fail++;
        end_sim();
    end
endmodule : tb_top
